// *** src/four_level_interrupt_controller.sv ***
// four-level interrupt controller with enable and priority registers
// What this block does
// RQ1: accepts six sources including both external inputs
// RQ2: each source gated by own enable bit
// RQ3: global enable bit 7 masks every source
// RQ4: two priority bits give levels zero to three
// RQ5: preempt only by strictly higher level
// RQ6: higher level wins among simultaneous requests
// RQ7: equal level resolved by fixed polling order
// RQ8: fixed vector address for each source
// RQ9: bit 6 enables counter array interrupt
// RQ10: bits 3 and 1 enable timer interrupts
// RQ11: bits 0 and 2 enable external interrupts
// RQ12: second enable bit 2 enables serial interrupt
// RQ13: enable register resets to zero, bitwise writable
// RQ14: reserved bits read zero, software writes none
// RQ15: priority bit positions match enable positions
// RQ16: serial priority at bit 2 of second pair
// RQ17: track in-service levels, release on return
// RQ18: sample once per machine cycle, one request
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_cfg.svh"
module four_level_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        MACHINE_CYCLE_I,
  input  wire logic        EXT_IRQ_ZERO_I,
  input  wire logic        EXT_IRQ_ONE_I,
  input  wire logic        TIMER_ZERO_OVERFLOW_FLAG_I,
  input  wire logic        TIMER_ONE_OVERFLOW_FLAG_I,
  input  wire logic        COUNTER_ARRAY_IRQ_I,
  input  wire logic        SERIAL_PERIPH_IRQ_I,
  input  wire logic        SFR_WR_I,
  input  wire logic        SFR_RD_I,
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  input  wire logic        VECTOR_ACK_I,
  input  wire logic        RETI_I,
  output logic      [7:0]  SFR_RDATA_O,
  output logic             VECTOR_REQ_O,
  output logic      [15:0] VECTOR_ADDR_O,
  output logic      [1:0]  ACTIVE_LEVEL_O,
  output logic             IN_SERVICE_O
);

  logic [7:0]  ie0_q, ie1_q, pl0_q, pl1_q, ph0_q, ph1_q;
  logic [5:0]  src_s1_q, src_s2_q;
  logic [3:0]  in_service_q;
  logic [5:0]  en_vec, pl_vec, ph_vec, pend;
  logic [1:0]  win_lvl;
  logic [2:0]  win_idx;
  logic        win_valid;
  logic        req_q;
  logic [15:0] vec_q;
  logic [1:0]  req_lvl_q;
  logic [7:0]  rdata_q;
  req_state_t  state_q;

  // bit-slice of a per-source field, ordered by polling number
  function automatic logic [5:0] src_bits(input logic [7:0] r0, input logic [7:0] r1);
    src_bits = {r1[`BIT_SERIAL], r0[`BIT_CNT_ARRAY], r0[`BIT_TIMER_ONE],
                r0[`BIT_EXT_ONE], r0[`BIT_TIMER_ZERO], r0[`BIT_EXT_ZERO]}; // RQ15 RQ16
  endfunction : src_bits

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0:    vec_of = `VEC_EXT_ZERO;
      3'h1:    vec_of = `VEC_TIMER_ZERO;
      3'h2:    vec_of = `VEC_EXT_ONE;
      3'h3:    vec_of = `VEC_TIMER_ONE;
      3'h4:    vec_of = `VEC_CNT_ARRAY;
      default: vec_of = `VEC_SERIAL;
    endcase // RQ8
  endfunction : vec_of

  // requests come from pins and other blocks, so synchronise first
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      src_s1_q <= 6'h00;
      src_s2_q <= 6'h00;
    end else begin
      src_s1_q <= {SERIAL_PERIPH_IRQ_I, COUNTER_ARRAY_IRQ_I, TIMER_ONE_OVERFLOW_FLAG_I,
                   EXT_IRQ_ONE_I, TIMER_ZERO_OVERFLOW_FLAG_I, EXT_IRQ_ZERO_I}; // RQ1
      src_s2_q <= src_s1_q;
    end
  end

  // register writes; reserved bits never stored so they read zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ie0_q <= `RESET_REG; // RQ13
      ie1_q <= `RESET_REG;
      pl0_q <= `RESET_REG;
      pl1_q <= `RESET_REG;
      ph0_q <= `RESET_REG;
      ph1_q <= `RESET_REG;
    end else if (SFR_WR_I) begin
      case (SFR_ADDR_I)
        `ADDR_IE_PRIMARY:   ie0_q <= SFR_WDATA_I & `MASK_REG0; // RQ13 RQ14
        `ADDR_IE_SECONDARY: ie1_q <= SFR_WDATA_I & `MASK_REG1; // RQ12 RQ14
        `ADDR_PRIO_LOW0:    pl0_q <= SFR_WDATA_I & `MASK_REG0; // RQ15
        `ADDR_PRIO_LOW1:    pl1_q <= SFR_WDATA_I & `MASK_REG1; // RQ16
        `ADDR_PRIO_HIGH0:   ph0_q <= SFR_WDATA_I & `MASK_REG0; // RQ15
        `ADDR_PRIO_HIGH1:   ph1_q <= SFR_WDATA_I & `MASK_REG1; // RQ16
        default: ;
      endcase
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      rdata_q <= 8'h00;
    end else if (SFR_RD_I) begin
      case (SFR_ADDR_I)
        `ADDR_IE_PRIMARY:   rdata_q <= ie0_q;
        `ADDR_IE_SECONDARY: rdata_q <= ie1_q;
        `ADDR_PRIO_LOW0:    rdata_q <= pl0_q;
        `ADDR_PRIO_LOW1:    rdata_q <= pl1_q;
        `ADDR_PRIO_HIGH0:   rdata_q <= ph0_q;
        `ADDR_PRIO_HIGH1:   rdata_q <= ph1_q;
        default:            rdata_q <= 8'h00;
      endcase
    end
  end

  // masking by per-source and global enables
  assign en_vec = src_bits(ie0_q, ie1_q); // RQ2 RQ9 RQ10 RQ11 RQ12
  assign pl_vec = src_bits(pl0_q, pl1_q);
  assign ph_vec = src_bits(ph0_q, ph1_q);
  assign pend   = src_s2_q & en_vec & {6{ie0_q[`BIT_GLOBAL]}}; // RQ3

  // highest level first, lowest polling number within a level
  always_comb begin
    win_valid = 1'b0;
    win_lvl   = 2'h0;
    win_idx   = 3'h0;
    for (int i = `NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!win_valid || {ph_vec[i], pl_vec[i]} >= win_lvl)) begin // RQ4 RQ6 RQ7
        win_valid = 1'b1;
        win_lvl   = {ph_vec[i], pl_vec[i]};
        win_idx   = 3'(i);
      end
    end
  end

  // a strictly higher level than any in service may preempt
  function automatic logic may_preempt(input logic [3:0] svc, input logic [1:0] lvl);
    may_preempt = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (svc[k] && 2'(k) >= lvl) may_preempt = 1'b0; // RQ5
    end
  endfunction : may_preempt

  // one request at a time, launched only on a machine cycle strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      state_q   <= ST_IDLE;
      req_q     <= 1'b0;
      vec_q     <= 16'h0000;
      req_lvl_q <= 2'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (MACHINE_CYCLE_I && win_valid && may_preempt(in_service_q, win_lvl)) begin // RQ18
            state_q   <= ST_WAIT_ACK;
            req_q     <= 1'b1;
            vec_q     <= vec_of(win_idx); // RQ8
            req_lvl_q <= win_lvl;
          end
        end
        ST_WAIT_ACK: begin
          if (VECTOR_ACK_I) begin
            state_q <= ST_IDLE;
            req_q   <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          req_q   <= 1'b0;
        end
      endcase
    end
  end

  // in-service stack: ack sets the level, return clears the highest
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      in_service_q <= 4'h0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (state_q == ST_WAIT_ACK && VECTOR_ACK_I && req_lvl_q == 2'(k)) begin
          in_service_q[k] <= 1'b1; // RQ17
        end else if (RETI_I && in_service_q[k] && (in_service_q >> (k + 1)) == 4'h0) begin
          in_service_q[k] <= 1'b0; // RQ17
        end
      end
    end
  end

  // status outputs, all registered
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ACTIVE_LEVEL_O <= 2'h0;
      IN_SERVICE_O   <= 1'b0;
    end else begin
      ACTIVE_LEVEL_O <= in_service_q[3] ? 2'h3 : in_service_q[2] ? 2'h2 :
                        in_service_q[1] ? 2'h1 : 2'h0;
      IN_SERVICE_O   <= |in_service_q;
    end
  end

  assign SFR_RDATA_O   = rdata_q;
  assign VECTOR_REQ_O  = req_q;
  assign VECTOR_ADDR_O = vec_q;

endmodule : four_level_interrupt_controller
`default_nettype wire

// *** src/irq_ctrl_cfg.svh ***
// register addresses, bit positions, vectors and reset values for the interrupt controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH
`define ADDR_IE_PRIMARY   8'ha8
`define ADDR_IE_SECONDARY 8'hb1
`define ADDR_PRIO_LOW0    8'hb8
`define ADDR_PRIO_LOW1    8'hb2
`define ADDR_PRIO_HIGH0   8'hb7
`define ADDR_PRIO_HIGH1   8'hb3
`define BIT_GLOBAL        7
`define BIT_CNT_ARRAY     6
`define BIT_TIMER_ONE     3
`define BIT_EXT_ONE       2
`define BIT_TIMER_ZERO    1
`define BIT_EXT_ZERO      0
`define BIT_SERIAL        2
`define MASK_REG0         8'hcf
`define MASK_REG1         8'h04
`define RESET_REG         8'h00
`define VEC_EXT_ZERO      16'h0003
`define VEC_TIMER_ZERO    16'h000b
`define VEC_EXT_ONE       16'h0013
`define VEC_TIMER_ONE     16'h001b
`define VEC_CNT_ARRAY     16'h0033
`define VEC_SERIAL        16'h004b
`define NUM_SRC           6
`endif

// *** src/irq_ctrl_pkg.sv ***
// types shared by the interrupt controller
package irq_ctrl_pkg;
  typedef logic [1:0] level_t;
  typedef enum logic [2:0] {
    SRC_EXT_ZERO, SRC_TIMER_ZERO, SRC_EXT_ONE, SRC_TIMER_ONE, SRC_CNT_ARRAY, SRC_SERIAL
  } src_t;
  typedef enum {ST_IDLE, ST_WAIT_ACK} req_state_t;
endpackage : irq_ctrl_pkg

// *** tb/irq_ctrl_props.sv ***
// port-level assertions for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_cfg.svh"
module irq_ctrl_props (
  input wire logic        CLK_SYS_I,
  input wire logic        SYS_RST_I,
  input wire logic        MACHINE_CYCLE_I,
  input wire logic        SFR_RD_I,
  input wire logic [7:0]  SFR_ADDR_I,
  input wire logic        VECTOR_ACK_I,
  input wire logic        RETI_I,
  input wire logic [7:0]  SFR_RDATA_O,
  input wire logic        VECTOR_REQ_O,
  input wire logic [15:0] VECTOR_ADDR_O,
  input wire logic [1:0]  ACTIVE_LEVEL_O,
  input wire logic        IN_SERVICE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  // vector handshake and nesting
  req_hold_a: assert property (VECTOR_REQ_O && !VECTOR_ACK_I |=>
    VECTOR_REQ_O && $stable(VECTOR_ADDR_O)) else $error("request moved before ack");
  req_drop_a: assert property (VECTOR_REQ_O && VECTOR_ACK_I |=> !VECTOR_REQ_O)
    else $error("request held after ack");
  req_start_a: assert property ($rose(VECTOR_REQ_O) |-> $past(MACHINE_CYCLE_I))
    else $error("request outside machine cycle");
  ack_service_a: assert property (VECTOR_REQ_O && VECTOR_ACK_I |-> ##2 IN_SERVICE_O)
    else $error("ack not marked in service");
  level_idle_a: assert property (!IN_SERVICE_O |-> ACTIVE_LEVEL_O == 2'h0)
    else $error("level shown while idle");
  top_level_a: assert property (IN_SERVICE_O && ACTIVE_LEVEL_O == 2'h3 && !RETI_I &&
    !$past(RETI_I) |=> !$rose(VECTOR_REQ_O)) else $error("top level preempted");
  vec_legal_a: assert property (VECTOR_REQ_O |-> VECTOR_ADDR_O[2:0] == 3'h3)
    else $error("vector off its slot");
  reserved_zero_a: assert property (SFR_RD_I && SFR_ADDR_I == `ADDR_IE_SECONDARY |=>
    (SFR_RDATA_O & ~`MASK_REG1) == 8'h00) else $error("reserved bits set");
  // main scenarios reached
  cover property (VECTOR_REQ_O && VECTOR_ACK_I);
  cover property (IN_SERVICE_O && ACTIVE_LEVEL_O == 2'h3);
  cover property ($rose(VECTOR_REQ_O) && IN_SERVICE_O);
endmodule : irq_ctrl_props
bind four_level_interrupt_controller irq_ctrl_props irq_ctrl_props_i (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .MACHINE_CYCLE_I(MACHINE_CYCLE_I),
  .SFR_RD_I(SFR_RD_I), .SFR_ADDR_I(SFR_ADDR_I), .VECTOR_ACK_I(VECTOR_ACK_I),
  .RETI_I(RETI_I), .SFR_RDATA_O(SFR_RDATA_O), .VECTOR_REQ_O(VECTOR_REQ_O),
  .VECTOR_ADDR_O(VECTOR_ADDR_O), .ACTIVE_LEVEL_O(ACTIVE_LEVEL_O),
  .IN_SERVICE_O(IN_SERVICE_O));
`default_nettype wire

// *** tb/cpu_seq_model.sv ***
// cpu sequencer model: acks vectors after a stall, returns on command
`timescale 1ns/1ns
`default_nettype none
module cpu_seq_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       reti_go_i,
  output logic            ack_o,
  output logic            reti_o
);
  logic [3:0] wait_q;
  // one ack pulse per request after delay_i stall cycles
  always_ff @(posedge clk_i) begin
    wait_q <= (req_i && !ack_o && !rst_i) ? wait_q + 4'h1 : 4'h0;
    ack_o  <= req_i && !ack_o && !rst_i && wait_q == delay_i;
  end
  // return pulse only when the bench asks
  always_ff @(posedge clk_i) reti_o <= reti_go_i && !rst_i;
endmodule : cpu_seq_model
`default_nettype wire

// *** tb/four_level_interrupt_controller_tb_top.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "irq_ctrl_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module four_level_interrupt_controller_tb_top;
  logic        clk = 1'b0, rst = 1'b1, mc = 1'b0, wen = 1'b0, ren = 1'b0, go = 1'b0;
  logic [5:0]  src = 6'h00;
  logic [7:0]  adr = 8'h00, wd = 8'h00, rdat;
  logic [3:0]  dly = 4'h1;
  logic        req, ack, reti, insv;
  logic [15:0] va;
  logic [1:0]  lvl;
  logic [15:0] vt [6] = '{`VEC_EXT_ZERO, `VEC_TIMER_ZERO, `VEC_EXT_ONE, `VEC_TIMER_ONE,
                          `VEC_CNT_ARRAY, `VEC_SERIAL};
  int          fail_count = 0, num_checks = 0, cyc = 0;
  four_level_interrupt_controller four_level_interrupt_controller_i (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .MACHINE_CYCLE_I(mc), .EXT_IRQ_ZERO_I(src[0]),
    .TIMER_ZERO_OVERFLOW_FLAG_I(src[1]), .EXT_IRQ_ONE_I(src[2]),
    .TIMER_ONE_OVERFLOW_FLAG_I(src[3]), .COUNTER_ARRAY_IRQ_I(src[4]),
    .SERIAL_PERIPH_IRQ_I(src[5]), .SFR_WR_I(wen), .SFR_RD_I(ren), .SFR_ADDR_I(adr),
    .SFR_WDATA_I(wd), .VECTOR_ACK_I(ack), .RETI_I(reti), .SFR_RDATA_O(rdat),
    .VECTOR_REQ_O(req), .VECTOR_ADDR_O(va), .ACTIVE_LEVEL_O(lvl), .IN_SERVICE_O(insv));
  cpu_seq_model cpu_seq_model_i (.clk_i(clk), .rst_i(rst), .req_i(req), .delay_i(dly),
    .reti_go_i(go), .ack_o(ack), .reti_o(reti));
  // clock, machine strobe every fourth cycle, hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mc  <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  // extra edge after the strobe drops keeps writes from colliding
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    adr <= a;
    wd  <= d;
    wen <= 1'b1;
    @(posedge clk);
    wen <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    adr <= a;
    ren <= 1'b1;
    @(posedge clk);
    ren <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(rdat, e)
  endtask : rchk
  // wait for the cpu ack, then check vector and level now in service
  task automatic take(input logic [15:0] e, input logic [1:0] l);
    repeat (80) if (ack !== 1'b1) @(posedge clk);
    `CHK(ack, 1'b1)
    `CHK(va, e)
    repeat (3) @(posedge clk);
    `CHK(lvl, l)
    `CHK(insv, 1'b1)
    $display("vector %h step done", e);
  endtask : take
  task automatic quiet();
    repeat (40) begin
      @(posedge clk);
      `CHK(req, 1'b0)
    end
    $display("hold step done");
  endtask : quiet
  task automatic rel();
    repeat (3) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : rel
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // registers, vectors, masking, polling and nesting
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(`ADDR_IE_PRIMARY, `RESET_REG);
    // software never sets reserved bits, so only implemented bits are written
    wr(`ADDR_IE_PRIMARY, `MASK_REG0);
    wr(`ADDR_IE_SECONDARY, `MASK_REG1);
    rchk(`ADDR_IE_PRIMARY, `MASK_REG0);
    rchk(`ADDR_IE_SECONDARY, `MASK_REG1);
    rchk(8'h00, 8'h00);
    $display("register step done");
    for (int i = 0; i < 6; i++) begin
      src <= 6'(1 << i);
      take(vt[i], 2'h0);
      src <= 6'h00;
      rel();
    end
    // raise sources only once the mask stands, else a strobe may catch them
    wr(`ADDR_IE_SECONDARY, 8'h00);
    wr(`ADDR_IE_PRIMARY, 8'h4f);
    src <= 6'h3f;
    quiet();
    wr(`ADDR_IE_PRIMARY, 8'h80);
    quiet();
    dly <= 4'h7;
    wr(`ADDR_IE_PRIMARY, `MASK_REG0);
    wr(`ADDR_IE_SECONDARY, `MASK_REG1);
    take(`VEC_EXT_ZERO, 2'h0);
    quiet();
    wr(`ADDR_PRIO_LOW0, 8'h02);
    take(`VEC_TIMER_ZERO, 2'h1);
    wr(`ADDR_PRIO_LOW1, 8'h04);
    wr(`ADDR_PRIO_HIGH1, 8'h04);
    take(`VEC_SERIAL, 2'h3);
    rchk(`ADDR_PRIO_LOW0, 8'h02);
    rchk(`ADDR_PRIO_HIGH1, `MASK_REG1);
    wr(`ADDR_PRIO_HIGH0, 8'h08);
    quiet();
    src <= 6'h1f;
    rel();
    take(`VEC_TIMER_ONE, 2'h2);
    // sources dropped first so the freed level is not refilled at once
    src <= 6'h00;
    rel();
    `CHK(lvl, 2'h1)
    $display("release step done");
    end_sim();
  end
endmodule : four_level_interrupt_controller_tb_top
`default_nettype wire
